// [rtl/sbl_map.svh]
// Register offsets, field positions, reset values and timing counts
// of the serial boot loader. Assumes an APB register bus.
`ifndef SBL_MAP_SVH
`define SBL_MAP_SVH
`define SBL_OFF_CTRL   8'h00
`define SBL_OFF_BAUD   8'h04
`define SBL_OFF_STAT   8'h08
`define SBL_OFF_LEN    8'h0C
`define SBL_OFF_PORT   8'h10
`define SBL_CTRL_RX    0
`define SBL_CTRL_TX    1
`define SBL_PORT_DIR   0
`define SBL_PORT_DAT   1
`define SBL_STAT_BOOT  16
`define SBL_STAT_MD7   17
`define SBL_STAT_FWE   18
`define SBL_BAUD_RST   16'h0000
`define SBL_LEN_RST    16'h0400
`define SBL_JUMP_ADDR  20'hFF300
`define SBL_ZERO_BYTE  8'h00
`define SBL_SYNC_BYTE  8'h55
`define SBL_CLK_HZ     100000000
`define SBL_RDY_STATES 100
`define SBL_STATE_CYC  1
`define SBL_BPS_HI     9600
`define SBL_BPS_LO     4800
`define SBL_LOW_BITS   9
`define SBL_TOL_DIV    32
`endif

// [rtl/sbl_pkg.sv]
// Types shared by the serial boot loader modules.
// Assumes nothing beyond a SystemVerilog compiler.
package sbl_pkg;
  // Loader sequence, one-hot coded.
  typedef enum logic [9:0] {
    ST_WAIT  = 10'h001,
    ST_ERASE = 10'h002,
    ST_HUNT  = 10'h004,
    ST_LOW   = 10'h008,
    ST_ACK   = 10'h010,
    ST_SYNC  = 10'h020,
    ST_LOAD  = 10'h040,
    ST_SHUT  = 10'h080,
    ST_RUN   = 10'h100,
    ST_USER  = 10'h200
  } sbl_state_t;
endpackage

// [rtl/sbl_uart_if.sv]
// Bundle between the loader sequencer and its serial transmitter and
// receiver. Assumes all three sit on one clock.
`timescale 1ns/1ps
`default_nettype none
interface sbl_uart_if;
  logic [15:0] divisor;  // Clocks per serial bit.
  logic        rx_on;    // Receiver enable.
  logic        tx_on;    // Transmitter enable.
  logic        tx_start; // Send request, one cycle.
  logic [7:0]  tx_data;  // Byte to send.
  logic        tx_busy;  // Frame in progress.
  logic        tx_line;  // Serial output level.
  logic        rx_valid; // Byte received, one cycle.
  logic [7:0]  rx_data;  // Received byte.
  logic        rx_err;   // Stop bit was low, one cycle.
  modport ctl (output divisor, rx_on, tx_on, tx_start, tx_data,
               input tx_busy, tx_line, rx_valid, rx_data, rx_err);
  modport tx  (input divisor, tx_on, tx_start, tx_data,
               output tx_busy, tx_line);
  modport rx  (input divisor, rx_on,
               output rx_valid, rx_data, rx_err);
endinterface // sbl_uart_if
`default_nettype wire

// [rtl/sbl_uart_tx.sv]
// Asynchronous transmitter: start bit, eight data bits, one stop bit.
// Assumes a divisor of at least two clocks per bit.
`timescale 1ns/1ps
`default_nettype none
module sbl_uart_tx (
  input wire logic clk,
  input wire logic rstn,
  sbl_uart_if.tx   u
);
  logic [15:0] cnt;   // Clocks left in the current bit.
  logic [3:0]  left;  // Bits left after the current one.
  logic [8:0]  shift; // Data bits then the stop bit.
  wire         tick = (cnt == 16'h0000); // Bit-rate enable.

  // One frame per request; no parity bit is ever added.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 16'h0000;
      left <= 4'h0;
      shift <= 9'h1FF;
      u.tx_busy <= 1'b0;
      u.tx_line <= 1'b1;
    end else if (!u.tx_on) begin
      // A disabled transmitter idles high.
      u.tx_busy <= 1'b0;
      u.tx_line <= 1'b1;
    end else if (!u.tx_busy) begin
      if (u.tx_start) begin
        shift <= {1'b1, u.tx_data};
        left <= 4'h9;
        cnt <= u.divisor - 16'h0001;
        u.tx_busy <= 1'b1;
        u.tx_line <= 1'b0;
      end
    end else if (tick) begin
      cnt <= u.divisor - 16'h0001;
      if (left == 4'h0) begin
        u.tx_busy <= 1'b0;
      end else begin
        u.tx_line <= shift[0];
        shift <= {1'b1, shift[8:1]};
        left <= left - 4'h1;
      end
    end else begin
      cnt <= cnt - 16'h0001;
    end
  end
endmodule // sbl_uart_tx
`default_nettype wire

// [rtl/sbl_uart_rx.sv]
// Asynchronous receiver sampling mid-bit, 8N1 frames.
// Assumes the line input is already synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module sbl_uart_rx (
  input wire logic clk,
  input wire logic rstn,
  input wire logic line,
  sbl_uart_if.rx   u
);
  logic        busy;    // Frame in progress.
  logic        idle_ok; // Line seen high since enable.
  logic [15:0] cnt;     // Clocks to the next sample.
  logic [3:0]  bitn;    // Index of the bit being sampled.

  // Sample each bit at its centre; a low stop bit is an error.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      idle_ok <= 1'b0;
      cnt <= 16'h0000;
      bitn <= 4'h0;
      u.rx_data <= 8'h00;
      u.rx_valid <= 1'b0;
      u.rx_err <= 1'b0;
    end else if (!u.rx_on) begin
      // Re-enabling waits for idle, so a byte caught midway is dropped.
      busy <= 1'b0;
      idle_ok <= 1'b0;
      u.rx_valid <= 1'b0;
      u.rx_err <= 1'b0;
    end else begin
      u.rx_valid <= 1'b0;
      u.rx_err <= 1'b0;
      if (!busy) begin
        if (line) begin
          idle_ok <= 1'b1;
        end else if (idle_ok) begin
          busy <= 1'b1;
          cnt <= {1'b0, u.divisor[15:1]};
          bitn <= 4'h0;
        end
      end else if (cnt != 16'h0000) begin
        cnt <= cnt - 16'h0001;
      end else begin
        cnt <= u.divisor - 16'h0001;
        bitn <= bitn + 4'h1;
        if (bitn == 4'h0) begin
          // A start bit that is gone at its centre was a glitch.
          busy <= line ? 1'b0 : 1'b1;
        end else if (bitn < 4'h9) begin
          u.rx_data <= {line, u.rx_data[7:1]};
        end else begin
          busy <= 1'b0;
          u.rx_valid <= line;
          u.rx_err <= ~line;
        end
      end
    end
  end
endmodule // sbl_uart_rx
`default_nettype wire

// [rtl/sbl_boot_top.sv]
// Serial boot loader: mode latch, bit-rate measurement, handshake,
// program load into RAM and hand-over to the loaded program.
// Assumes synchronous pin inputs, an APB master and a flash eraser.
`timescale 1ns/1ps
`default_nettype none
`include "sbl_map.svh"
// Summary of operation
// - Serial channel one runs asynchronous in boot.
// - Host zero bytes; low period sets divisor.
// - Frames are eight data bits, one stop.
// - Send one zero byte after rate found.
// - Clock range limits guaranteed rate adjustment.
// - Load program into RAM, jump 0xFF300.
// - Clear serial enables, keep baud divisor.
// - Transmit line left driven high on jump.
// - Wait about 100 states before measuring.
// - Erase all flash unless already blank.
// - Latch mode pins at reset release.
// - Watchdog reset restarts loader, keeps mode.
module sbl_boot_top #(
  parameter int BIT_MIN = `SBL_CLK_HZ / `SBL_BPS_HI
                        - `SBL_CLK_HZ / `SBL_BPS_HI / `SBL_TOL_DIV,
  parameter int BIT_MAX = `SBL_CLK_HZ / `SBL_BPS_LO
                        + `SBL_CLK_HZ / `SBL_BPS_LO / `SBL_TOL_DIV
) (
  input  wire logic        MCLK,
  input  wire logic        RSTN,
  input  wire logic        WDT_RST,
  input  wire logic [2:0]  MODE_SELECT_PINS,
  input  wire logic        PROGRAM_ENABLE_PIN,
  input  wire logic        HOST_RX_LINE,
  output logic             HOST_TX_LINE,
  output logic             HOST_TX_OE_N,
  input  wire logic        FLASH_BLANK,
  input  wire logic        FLASH_ERASE_DONE,
  output logic             FLASH_ERASE_ALL,
  output logic             RAM_WE,
  output logic [19:0]      RAM_ADDR,
  output logic [7:0]       RAM_WDATA,
  output logic             CPU_JUMP,
  output logic [19:0]      JUMP_ADDR,
  output logic             BOOT_MODE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);
  // Startup wait, in clocks, before the low period is looked for.
  localparam int RDY_CYC = `SBL_RDY_STATES * `SBL_STATE_CYC;
  localparam logic [7:0] RDY_LAST = 8'(RDY_CYC - 1);

  sbl_pkg::sbl_state_t st;      // Loader sequence state.
  sbl_pkg::sbl_state_t next_st; // Its next value.

  logic        latched;   // Mode pins have been captured.
  logic        mode7;     // Mode 7 rather than mode 5.
  logic        fwe_l;     // Captured program-enable level.
  logic [7:0]  rdy_cnt;   // Startup wait counter.
  logic [19:0] low_cnt;   // Clocks of the measured low period.
  logic        rx_prev;   // Receive line one clock ago.
  logic        ack_sent;  // Adjustment-end byte was requested.
  logic [15:0] load_cnt;  // Bytes stored so far.
  logic [15:0] prog_len;  // Bytes to load before the jump.
  logic [15:0] baud_divisor_register; // Clocks per serial bit.
  logic        rx_on_bit;             // Receiver enable.
  logic        tx_on_bit;             // Transmitter enable.
  logic        port_direction_register; // Transmit pin is output.
  logic        port_output_register;    // Transmit pin level.
  logic        tx_start;  // Send request to the transmitter.

  sbl_uart_if u ();

  // Sequencer drives the serial controls from its own flip-flops; the send byte is a constant zero.
  assign u.divisor = baud_divisor_register;
  assign u.rx_on = rx_on_bit;
  assign u.tx_on = tx_on_bit;
  assign u.tx_start = tx_start;
  assign u.tx_data = `SBL_ZERO_BYTE;

  // Channel one in asynchronous 8N1 mode carries all host traffic.
  sbl_uart_tx u_tx (
    .clk  (MCLK),
    .rstn (RSTN),
    .u    (u.tx)
  );

  sbl_uart_rx u_rx (
    .clk  (MCLK),
    .rstn (RSTN),
    .line (HOST_RX_LINE),
    .u    (u.rx)
  );

  // State decode.
  wire st_wait  = (st == sbl_pkg::ST_WAIT);
  wire st_erase = (st == sbl_pkg::ST_ERASE);
  wire st_hunt  = (st == sbl_pkg::ST_HUNT);
  wire st_low   = (st == sbl_pkg::ST_LOW);
  wire st_ack   = (st == sbl_pkg::ST_ACK);
  wire st_sync  = (st == sbl_pkg::ST_SYNC);
  wire st_load  = (st == sbl_pkg::ST_LOAD);
  wire st_shut  = (st == sbl_pkg::ST_SHUT);
  wire st_run   = (st == sbl_pkg::ST_RUN);
  wire st_user  = (st == sbl_pkg::ST_USER);

  // Boot needs enable high, bit zero high and bit two low.
  wire boot_pins = PROGRAM_ENABLE_PIN & MODE_SELECT_PINS[0]
                 & ~MODE_SELECT_PINS[2];
  // A watchdog reset in boot mode only restarts the sequence.
  wire restart = WDT_RST & BOOT_MODE;
  wire rdy_done = latched & (rdy_cnt == RDY_LAST);

  // Low period covers start bit and eight zero data bits.
  wire [20:0] meas_sum = {1'b0, low_cnt} + 21'h000004;
  wire [20:0] meas_bit = meas_sum / 21'(`SBL_LOW_BITS);
  // Only periods from just under the 9600 bit time to just over the 4800 bit time are trusted.
  wire meas_ok = (meas_bit >= 21'(BIT_MIN))
               & (meas_bit <= 21'(BIT_MAX));
  wire low_end = st_low & HOST_RX_LINE;
  wire low_ovf = st_low & (low_cnt == 20'hFFFFF);
  wire fall = rx_prev & ~HOST_RX_LINE;
  // The host's reply byte opens the load phase.
  wire sync_hit = u.rx_valid & (u.rx_data == `SBL_SYNC_BYTE);
  wire [16:0] load_nxt = {1'b0, load_cnt} + 17'h00001;
  wire load_last = (load_nxt >= {1'b0, prog_len});

  // Sequence from startup through hand-over.
  always_comb begin
    next_st = st;
    case (st)
      sbl_pkg::ST_WAIT: begin
        if (latched & ~BOOT_MODE) begin
          next_st = sbl_pkg::ST_USER;
        end else if (rdy_done) begin
          // Blank flash skips the full erase.
          next_st = FLASH_BLANK ? sbl_pkg::ST_HUNT
                                : sbl_pkg::ST_ERASE;
        end
      end
      sbl_pkg::ST_ERASE: begin
        if (FLASH_ERASE_DONE) begin
          next_st = sbl_pkg::ST_HUNT;
        end
      end
      sbl_pkg::ST_HUNT: begin
        if (fall) begin
          next_st = sbl_pkg::ST_LOW;
        end
      end
      sbl_pkg::ST_LOW: begin
        if (low_end) begin
          next_st = meas_ok ? sbl_pkg::ST_ACK : sbl_pkg::ST_HUNT;
        end else if (low_ovf) begin
          next_st = sbl_pkg::ST_HUNT;
        end
      end
      sbl_pkg::ST_ACK: begin
        if (ack_sent & ~tx_start & ~u.tx_busy) begin
          next_st = sbl_pkg::ST_SYNC;
        end
      end
      sbl_pkg::ST_SYNC: begin
        // Anything but the reply byte is skipped.
        if (sync_hit) begin
          next_st = sbl_pkg::ST_LOAD;
        end
      end
      sbl_pkg::ST_LOAD: begin
        if (u.rx_valid & load_last) begin
          next_st = sbl_pkg::ST_SHUT;
        end
      end
      sbl_pkg::ST_SHUT: begin
        next_st = sbl_pkg::ST_RUN;
      end
      sbl_pkg::ST_RUN: begin
        next_st = sbl_pkg::ST_RUN;
      end
      sbl_pkg::ST_USER: begin
        next_st = sbl_pkg::ST_USER;
      end
      default: begin
        next_st = sbl_pkg::ST_WAIT;
      end
    endcase
    if (restart) begin
      next_st = sbl_pkg::ST_WAIT;
    end
  end

  // Mode pins are captured once, in the first clock after release.
  // The watchdog path never reaches these flip-flops.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      latched <= 1'b0;
      BOOT_MODE <= 1'b0;
      mode7 <= 1'b0;
      fwe_l <= 1'b0;
    end else if (!latched) begin
      latched <= 1'b1;
      BOOT_MODE <= boot_pins;
      mode7 <= MODE_SELECT_PINS[1];
      fwe_l <= PROGRAM_ENABLE_PIN;
    end
  end

  // State register and the counters that follow it.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      st <= sbl_pkg::ST_WAIT;
      rdy_cnt <= 8'h00;
      low_cnt <= 20'h00000;
      rx_prev <= 1'b0;
      ack_sent <= 1'b0;
    end else begin
      st <= next_st;
      rx_prev <= HOST_RX_LINE;
      // Startup wait restarts whenever the line is low.
      rdy_cnt <= (st_wait & latched & HOST_RX_LINE & ~rdy_done)
               ? rdy_cnt + 8'h01 : 8'h00;
      low_cnt <= st_low ? low_cnt + 20'h00001 : 20'h00001;
      ack_sent <= st_ack & ~restart;
    end
  end

  // Adjustment-end byte is requested exactly once.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_start <= 1'b0;
    end else begin
      tx_start <= st_ack & ~ack_sent & ~restart;
    end
  end

  // APB decode; the loader owns the serial controls until the jump.
  wire apb_wr = PSEL & PENABLE & PREADY & PWRITE;
  wire sel_ctrl = (PADDR == `SBL_OFF_CTRL);
  wire sel_baud = (PADDR == `SBL_OFF_BAUD);
  wire sel_stat = (PADDR == `SBL_OFF_STAT);
  wire sel_len  = (PADDR == `SBL_OFF_LEN);
  wire sel_port = (PADDR == `SBL_OFF_PORT);
  wire sel_any = sel_ctrl | sel_baud | sel_stat | sel_len | sel_port;
  wire sw_ok = st_run | st_user;
  wire [1:0] serial_control_register = {tx_on_bit, rx_on_bit};
  wire [31:0] stat_val = {13'h0000, fwe_l, mode7, BOOT_MODE,
                          6'h00, st};
  wire [31:0] rd_val =
    sel_ctrl ? {30'h00000000, serial_control_register} :
    sel_baud ? {16'h0000, baud_divisor_register} :
    sel_stat ? stat_val :
    sel_len  ? {16'h0000, prog_len} :
    sel_port ? {30'h00000000, port_output_register,
                port_direction_register} : 32'h00000000;

  // Serial controls, divisor and transmit-pin port bits.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      baud_divisor_register <= `SBL_BAUD_RST;
      rx_on_bit <= 1'b0;
      tx_on_bit <= 1'b0;
      port_direction_register <= 1'b0;
      port_output_register <= 1'b0;
    end else if (restart) begin
      rx_on_bit <= 1'b0;
      tx_on_bit <= 1'b0;
      port_direction_register <= 1'b0;
      port_output_register <= 1'b0;
    end else if (low_end & meas_ok) begin
      baud_divisor_register <= meas_bit[15:0];
      tx_on_bit <= 1'b1;
    end else if (st_ack & (next_st == sbl_pkg::ST_SYNC)) begin
      rx_on_bit <= 1'b1;
    end else if (st_shut) begin
      // Enables drop; the divisor is left as measured.
      rx_on_bit <= 1'b0;
      tx_on_bit <= 1'b0;
      port_direction_register <= 1'b1;
      port_output_register <= 1'b1;
    end else if (apb_wr & sw_ok) begin
      if (sel_ctrl) begin
        rx_on_bit <= PWDATA[`SBL_CTRL_RX];
        tx_on_bit <= PWDATA[`SBL_CTRL_TX];
      end else if (sel_baud) begin
        baud_divisor_register <= PWDATA[15:0];
      end else if (sel_port) begin
        port_direction_register <= PWDATA[`SBL_PORT_DIR];
        port_output_register <= PWDATA[`SBL_PORT_DAT];
      end
    end
  end

  // Load length may be set at any time before the load ends.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      prog_len <= `SBL_LEN_RST;
    end else if (apb_wr & sel_len) begin
      prog_len <= PWDATA[15:0];
    end
  end

  // APB answer: ready in the first access cycle, no wait states.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL & ~PENABLE;
      PRDATA <= (PSEL & ~PENABLE & ~PWRITE) ? rd_val : 32'h00000000;
      PSLVERR <= PSEL & ~PENABLE & ~sel_any;
    end
  end

  // Received bytes go to RAM upward from the jump target.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      load_cnt <= 16'h0000;
      RAM_WE <= 1'b0;
      RAM_ADDR <= 20'h00000;
      RAM_WDATA <= 8'h00;
    end else begin
      RAM_WE <= st_load & u.rx_valid & ~restart;
      if (st_load & u.rx_valid) begin
        RAM_ADDR <= `SBL_JUMP_ADDR + {4'h0, load_cnt};
        RAM_WDATA <= u.rx_data;
        load_cnt <= load_nxt[15:0];
      end else if (st_sync) begin
        load_cnt <= 16'h0000;
      end
    end
  end

  // Erase request, jump and transmit pin; all registered.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      FLASH_ERASE_ALL <= 1'b0;
      CPU_JUMP <= 1'b0;
      JUMP_ADDR <= 20'h00000;
      HOST_TX_LINE <= 1'b1;
      HOST_TX_OE_N <= 1'b1;
    end else begin
      FLASH_ERASE_ALL <= (next_st == sbl_pkg::ST_ERASE);
      CPU_JUMP <= st_shut & ~restart ? 1'b1 : (CPU_JUMP & ~restart);
      if (st_shut) begin
        JUMP_ADDR <= `SBL_JUMP_ADDR;
      end
      // Port bits hold the line high once the channel is off.
      HOST_TX_LINE <= tx_on_bit ? u.tx_line
                    : (port_direction_register ? port_output_register
                                               : 1'b1);
      HOST_TX_OE_N <= ~(tx_on_bit | port_direction_register);
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  sequence s_measured;
    low_end & meas_ok & ~restart;
  endsequence

  sequence s_shut;
    st_shut & ~restart;
  endsequence

  a_ack_zero_byte: assert property (
    $rose(tx_start) |-> st_ack & (u.tx_data == 8'h00)
      ##1 u.tx_busy)
    else $error("Adjustment-end byte not a zero frame.");

  a_divisor_ninth: assert property (
    s_measured |=> baud_divisor_register ==
      16'(({1'b0, $past(low_cnt)} + 21'h000004) / 21'h000009))
    else $error("Divisor is not the low time over nine.");

  a_measure_ack: assert property (
    s_measured |=> st_ack & tx_on_bit ##1 tx_start)
    else $error("Measurement not followed by the end byte.");

  a_shut_enables: assert property (
    s_shut |=> st_run & ~rx_on_bit & ~tx_on_bit
      & $stable(baud_divisor_register))
    else $error("Shut-down lost divisor or kept enables.");

  a_tx_pin_high: assert property (
    s_shut |=> ##1 HOST_TX_LINE & ~HOST_TX_OE_N)
    else $error("Transmit pin not driven high at jump.");

  a_jump_target: assert property (
    $rose(CPU_JUMP) |-> JUMP_ADDR == 20'hFF300 && $past(st_shut))
    else $error("Jump not taken to the RAM load base.");

  a_ram_store: assert property (
    RAM_WE |-> $past(st_load) && RAM_ADDR >= 20'hFF300)
    else $error("RAM write outside the load phase.");

  a_startup_wait: assert property (
    $fell(st_wait) && $past(BOOT_MODE) |->
      $past(rdy_cnt) == 8'h63)
    else $error("Startup wait was not 100 clocks.");

  a_erase_unblank: assert property (
    st_wait & rdy_done & ~FLASH_BLANK & ~restart |=>
      st_erase & FLASH_ERASE_ALL)
    else $error("Non-blank flash was not fully erased.");

  a_mode_kept: assert property (
    $past(latched) |-> $stable(BOOT_MODE) & $stable(mode7))
    else $error("Latched mode changed after release.");

  a_wdt_restart: assert property (
    restart |=> st_wait & BOOT_MODE & ~rx_on_bit & ~tx_on_bit)
    else $error("Watchdog reset did not restart the loader.");
endmodule // sbl_boot_top
`default_nettype wire

// [verif/sbl_host_model.sv]
// Host model: zero bytes, reply check, sync byte, then the program.
// Assumes the device samples its receive line on clk.
`timescale 1ns/1ps
`default_nettype none
module sbl_host_model #(
  parameter int BIT = 40, // Scaled bit time of a supported rate.
  parameter int NB  = 4   // Program bytes; far below emulation RAM.
) (
  input  wire logic clk,
  input  wire logic dev_tx,
  output logic      host_tx
);
  logic [7:0] got; // Byte heard from the device.
  // One frame, least significant bit first, one stop.
  task automatic send(input logic [7:0] b);
    host_tx <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int k = 0; k < 9; k++) begin
      host_tx <= (k < 8) ? b[k] : 1'b1;
      repeat (BIT) @(posedge clk);
    end
  endtask
  // Mid-bit sampling of one device frame.
  task automatic recv();
    while (dev_tx !== 1'b0) @(posedge clk);
    repeat (BIT / 2) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      repeat (BIT) @(posedge clk);
      got[k] = dev_tx;
    end
  endtask
  // Idle high past reset and startup, so the wait can finish first.
  initial begin
    host_tx = 1'b1; // Idle level.
    got = 8'hFF;
    repeat (200) @(posedge clk);
    fork
      repeat (2) send(8'h00); // Zeros for measuring.
      recv();
    join
    // A bad reply calls for a reset and a fresh measurement; this model just stops sending.
    if (got === 8'h00) begin // Only a clean reply is answered.
      send(8'h55); // Sync byte.
      // Stand-in program; a real one sets registers and stack.
      // It must not lean on interrupts during flash work.
      for (int i = 0; i < NB; i++) send(8'h5A + i[7:0]);
    end
  end
endmodule // sbl_host_model
`default_nettype wire

// [verif/serial_boot_loader_autobaud_bench.sv]
// Bench: boot entry, load, hand-over, watchdog restart, boot exit.
// Assumes the host model and short bit-period limits.
`timescale 1ns/1ps
`default_nettype none
module serial_boot_loader_autobaud_bench;
  logic        mclk, rstn, wdt, pe, blank, edone, psel, pen, pwr, slverr;
  logic [2:0]  mode;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd;
  int          bad_count, check_count, n;
  wire logic        rxl, txl, oen, era, we, jmp, boot, rdy;
  wire logic [19:0] ra, ja;
  wire logic [7:0]  wd;
  wire logic [31:0] prdata;
  wire logic        perr;
  sbl_boot_top #(.BIT_MIN(20), .BIT_MAX(60)) i_sbl_boot_top (
    .MCLK(mclk), .RSTN(rstn), .WDT_RST(wdt), .MODE_SELECT_PINS(mode),
    .PROGRAM_ENABLE_PIN(pe), .HOST_RX_LINE(rxl), .HOST_TX_LINE(txl),
    .HOST_TX_OE_N(oen), .FLASH_BLANK(blank), .FLASH_ERASE_DONE(edone),
    .FLASH_ERASE_ALL(era), .RAM_WE(we), .RAM_ADDR(ra), .RAM_WDATA(wd),
    .CPU_JUMP(jmp), .JUMP_ADDR(ja), .BOOT_MODE(boot), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(rdy), .PSLVERR(perr));
  sbl_host_model i_sbl_host_model (.clk(mclk), .dev_tx(txl), .host_tx(rxl));
  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  // One APB transfer; the answer is taken where pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    pen <= 1'b1;
    do @(posedge mclk); while (rdy !== 1'b1);
    rd = prdata;
    slverr = perr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task automatic end_sim();
    if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Each stored byte must land at the next address with the sent value.
  always @(posedge mclk) if (we === 1'b1) begin
    chk("ram_addr", {12'h000, ra}, {12'h000, 20'hFF300 + n[19:0]});
    chk("ram_data", {24'h0, wd}, {24'h0, 8'h5A + n[7:0]});
    n++;
  end
  // A hang is cut short well beyond the expected run.
  initial begin
    repeat (30000) @(posedge mclk);
    bad_count++;
    end_sim();
  end
  initial begin
    {rstn, wdt, psel, pen, pwr, edone, blank} = '0;
    {paddr, pwdata, rd, slverr} = '0;
    // Mode 7 boot pins, left alone while the loader runs.
    mode = 3'b011;
    pe = 1'b1;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    apb(1'b1, 8'h0C, 32'h0000_0004);
    chk("boot_mode", {31'h0, boot}, 32'h1);
    apb(1'b1, 8'h04, 32'h0000_1234); // Refused until the jump.
    apb(1'b0, 8'h04, 32'h0);
    chk("baud_lock", rd, 32'h0);
    for (int t = 0; t < 500 && era !== 1'b1; t++) @(posedge mclk);
    chk("erase_all", {31'h0, era}, 32'h1);
    edone <= 1'b1;
    @(posedge mclk);
    edone <= 1'b0;
    for (int t = 0; t < 20000 && jmp !== 1'b1; t++) @(posedge mclk);
    @(posedge mclk);
    chk("ack_byte", {24'h0, i_sbl_host_model.got}, 32'h0);
    chk("jump_addr", {12'h000, ja}, {12'h000, 20'hFF300});
    chk("bytes", n, 4);
    chk("tx_level", {30'h0, oen, txl}, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk("baud", rd, 32'd40);
    apb(1'b0, 8'h10, 32'h0);
    chk("port", rd, 32'h3);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", {slverr, rd[30:0]}, 32'h8000_0000);
    mode <= 3'b000; wdt <= 1'b1; // Pins ignored on restart.
    @(posedge mclk);
    wdt <= 1'b0;
    apb(1'b0, 8'h08, 32'h0);
    chk("wdt_stat", rd & 32'h0007_03FF, 32'h0007_0001);
    chk("wdt_jump", {31'h0, jmp}, 32'h0);
    rstn <= 1'b0; pe <= 1'b0; mode <= 3'b001;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    // The pins are latched on the first edge and the state moves on
    // the second, so the status read waits for both.
    repeat (2) @(posedge mclk);
    apb(1'b0, 8'h08, 32'h0);
    // Software sees the enable bit low and must not start flash work.
    // Block-wise erase in user mode is left to that software.
    chk("exit_stat", rd & 32'h0007_03FF, 32'h0000_0200);
    end_sim();
  end
endmodule // serial_boot_loader_autobaud_bench
`default_nettype wire
